/* core/pag_guard.sv */
// Access guard for the setting store with direction limit and password lock
//
// The register addresses and the plain strobed port are this design's own decisions.
`timescale 1ns/1ns
module pag_guard import pag_pkg::*; (
   input wire logic clk_i,
   input wire logic rst_i,
   input wire logic [9:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   input wire pag_acc_s acc_i,
   output logic [15:0] rdata_o,
   output logic ack_o,
   output logic deny_o,
   output logic locked_indication_o,
   input wire logic running_i,
   input wire logic pu_connected_i,
   input wire logic all_clear_i,
   output logic clear_done_o,
   output logic clear_refused_o,
   input wire logic forward_start_i,
   input wire logic reverse_start_i,
   input wire pag_dir_s panel_dir_i,
   input wire pag_dir_s net_dir_i,
   output pag_dir_s run_dir_o,
   input wire logic nv_load_i,
   input wire pag_nv_s nv_i,
   output pag_nv_s nv_o
);

   //------------------------------------------------------------
   // State
   //------------------------------------------------------------
   typedef struct packed {
      logic [2:0] fsync;
      logic [2:0] rsync;
      logic fterm;
      logic rterm;
      logic [15:0] dirlim;
      logic [15:0] scope;
      logic [15:0] wguard;
      logic [15:0] lsrc;
      logic [15:0] level;
      logic [15:0] password;
      logic locked;
      logic [2:0] err;
      logic [15:0] rdata;
      logic ack;
      logic deny;
      logic locked_indication;
      logic clr_done;
      logic clr_ref;
      pag_dir_s dir;
   } pag_state_s;

   localparam pag_state_s ST_RST = '{
      fsync: 3'h0, rsync: 3'h0, fterm: 1'b0, rterm: 1'b0,
      dirlim: DL_BOTH, scope: SC_ALL, wguard: WG_STOP, lsrc: LS_RST,
      level: V_NONE, password: V_ZERO, locked: 1'b0, err: 3'h0,
      rdata: V_ZERO, ack: 1'b0, deny: 1'b0, locked_indication: 1'b0,
      clr_done: 1'b0, clr_ref: 1'b0, dir: 2'h0};

   pag_state_s st_ff;
   pag_state_s nxt_st;

   //------------------------------------------------------------
   // Helpers
   //------------------------------------------------------------
   // Lock level reduced to 1..6
   function automatic logic [2:0] lvl_idx(input logic [15:0] lv);
      if (lv >= LV_CNT_MIN) begin
         lvl_idx = 3'(lv - LV_CNT_BASE);
      end else begin
         lvl_idx = 3'(lv);
      end
   endfunction

   // Legal lock level value
   function automatic logic lvl_ok(input logic [15:0] lv);
      lvl_ok = (lv == V_NONE) || (lv >= LV_MIN && lv <= LV_MAX) ||
               (lv >= LV_CNT_MIN && lv <= LV_CNT_MAX);
   endfunction

   // Read and write rights of one port, {read, write}
   function automatic logic [1:0] rights(input logic [2:0] idx, input logic network_mode);
      unique case (idx)
         3'h1: rights = 2'b10;
         3'h2: rights = network_mode ? 2'b11 : 2'b10;
         3'h3: rights = network_mode ? 2'b10 : 2'b11;
         3'h4: rights = 2'b00;
         3'h5: rights = network_mode ? 2'b11 : 2'b00;
         3'h6: rights = network_mode ? 2'b00 : 2'b11;
         default: rights = 2'b11;
      endcase
   endfunction

   //------------------------------------------------------------
   // Access decision
   //------------------------------------------------------------
   logic counting;
   logic lockout;
   logic rd_scope_ok;
   logic wr_scope_ok;
   logic wg_ok;
   logic lock_exempt;
   logic [1:0] lock_rw;
   logic val_ok;
   logic rd_ok;
   logic wr_ok;

   always_comb begin
      counting = st_ff.level >= LV_CNT_MIN;
      lockout = st_ff.locked && counting && (st_ff.err == ERR_LIMIT);
      // Network sees all unless source 2
      rd_scope_ok = acc_i.simple || (st_ff.scope != SC_SIMPLE) ||
                    (acc_i.network_mode && st_ff.lsrc != LS_NET_SCOPE);
      wr_scope_ok = rd_scope_ok;
      if (addr_i == PN_LVL) begin
         wr_scope_ok = st_ff.scope == SC_ALL;
      end else if (addr_i == PN_ENTRY) begin
         wr_scope_ok = (st_ff.scope == SC_ALL) || (st_ff.level != V_NONE);
      end
      // Scope and lock writable while running
      unique case (st_ff.wguard)
         WG_STOP: wg_ok = !running_i || acc_i.anytime || addr_i == PN_SCOPE ||
                          addr_i == PN_LVL || addr_i == PN_ENTRY || addr_i == PN_WGUARD;
         WG_NONE: wg_ok = addr_i == PN_STALL_LVL || addr_i == PN_RESET_SEL ||
                          addr_i == PN_WGUARD || addr_i == PN_OPMODE || addr_i == PN_SCOPE ||
                          addr_i == PN_LVL || addr_i == PN_ENTRY;
         WG_ANY: wg_ok = !(running_i && acc_i.stoponly);
         default: wg_ok = 1'b0;
      endcase
      lock_exempt = !st_ff.locked || (addr_i == PN_CONTRAST && pu_connected_i) ||
                    addr_i == PN_ENTRY || addr_i == PN_LVL;
      lock_rw = lock_exempt ? 2'b11 : rights(lvl_idx(st_ff.level), acc_i.network_mode);
      unique case (addr_i)
         PN_DIRLIM: val_ok = wdata_i <= DL_NO_FWD;
         PN_SCOPE: val_ok = wdata_i == SC_ALL || wdata_i == SC_SIMPLE;
         PN_WGUARD: val_ok = wdata_i <= WG_ANY;
         PN_LVL: val_ok = lvl_ok(wdata_i) && !st_ff.locked;
         PN_ENTRY: val_ok = st_ff.level != V_NONE &&
                            (st_ff.locked || (wdata_i >= PW_MIN && wdata_i <= PW_MAX));
         default: val_ok = 1'b1;
      endcase
      // Scope, guard and lock rights must all pass; internal update overrides them
      rd_ok = rd_scope_ok && lock_rw[1];
      wr_ok = wr_scope_ok && wg_ok && lock_rw[0] && val_ok;
      if (acc_i.self_upd) begin
         rd_ok = 1'b1;
         wr_ok = 1'b1;
      end
   end

   //------------------------------------------------------------
   // Next state
   //------------------------------------------------------------
   always_comb begin
      nxt_st = st_ff;
      nxt_st.ack = 1'b0;
      nxt_st.deny = 1'b0;
      nxt_st.locked_indication = 1'b0;
      nxt_st.clr_done = 1'b0;
      nxt_st.clr_ref = 1'b0;
      nxt_st.rdata = V_ZERO;
      // Terminal inputs, accepted once stages two and three agree
      nxt_st.fsync = {st_ff.fsync[1:0], forward_start_i};
      nxt_st.rsync = {st_ff.rsync[1:0], reverse_start_i};
      if (st_ff.fsync[2] == st_ff.fsync[1]) begin
         nxt_st.fterm = st_ff.fsync[2];
      end
      if (st_ff.rsync[2] == st_ff.rsync[1]) begin
         nxt_st.rterm = st_ff.rsync[2];
      end
      // Limit applied to all sources alike
      nxt_st.dir.fwd = (panel_dir_i.fwd || net_dir_i.fwd || st_ff.fterm) &&
                       st_ff.dirlim != DL_NO_FWD;
      nxt_st.dir.rev = (panel_dir_i.rev || net_dir_i.rev || st_ff.rterm) &&
                       st_ff.dirlim != DL_NO_REV;
      if (rd_i) begin
         nxt_st.ack = rd_ok;
         nxt_st.deny = !rd_ok;
         nxt_st.locked_indication = !lock_rw[1] && !acc_i.self_upd;
         if (rd_ok) begin
            unique case (addr_i)
               PN_DIRLIM: nxt_st.rdata = st_ff.dirlim;
               PN_SCOPE: nxt_st.rdata = st_ff.scope;
               PN_WGUARD: nxt_st.rdata = st_ff.wguard;
               PN_LSRC: nxt_st.rdata = st_ff.lsrc;
               PN_LVL: nxt_st.rdata = st_ff.level;
               PN_ENTRY: nxt_st.rdata = !st_ff.locked ? V_NONE :
                                        counting ? {13'h0, st_ff.err} : V_ZERO;
               default: nxt_st.rdata = V_ZERO;
            endcase
         end
      end else if (wr_i) begin
         nxt_st.ack = wr_ok;
         nxt_st.deny = !wr_ok;
         nxt_st.locked_indication = !lock_rw[0] && !acc_i.self_upd;
         if (wr_ok) begin
            unique case (addr_i)
               PN_DIRLIM: nxt_st.dirlim = wdata_i;
               PN_SCOPE: nxt_st.scope = wdata_i;
               PN_WGUARD: nxt_st.wguard = wdata_i;
               PN_LSRC: nxt_st.lsrc = wdata_i;
               PN_LVL: nxt_st.level = wdata_i;
               PN_ENTRY: begin
                  if (!st_ff.locked) begin
                     nxt_st.password = wdata_i;
                     nxt_st.locked = 1'b1;
                     nxt_st.err = 3'h0;
                  end else if (!lockout) begin
                     if (wdata_i == st_ff.password) begin
                        nxt_st.locked = 1'b0;
                        nxt_st.err = 3'h0;
                     end else if (counting) begin
                        nxt_st.err = 3'(st_ff.err + 3'h1);
                     end
                  end
               end
               default: nxt_st.err = st_ff.err;
            endcase
         end
      end
      if (all_clear_i) begin
         if (running_i || st_ff.wguard == WG_NONE) begin
            nxt_st.clr_ref = 1'b1;
         end else begin
            nxt_st.dirlim = DL_BOTH;
            nxt_st.scope = SC_ALL;
            nxt_st.wguard = WG_STOP;
            nxt_st.lsrc = LS_RST;
            nxt_st.level = V_NONE;
            nxt_st.password = V_ZERO;
            nxt_st.locked = 1'b0;
            nxt_st.err = 3'h0;
            nxt_st.clr_done = 1'b1;
         end
      end
      if (nv_load_i && lvl_ok(nv_i.level)) begin
         nxt_st.level = nv_i.level;
         nxt_st.password = nv_i.password;
         nxt_st.locked = nv_i.locked && nv_i.level != V_NONE;
         nxt_st.err = (nv_i.err > ERR_LIMIT) ? ERR_LIMIT : nv_i.err;
      end
   end

   // State register
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         st_ff <= ST_RST;
      end else begin
         st_ff <= nxt_st;
      end
   end

   //------------------------------------------------------------
   // Outputs
   //------------------------------------------------------------
   // All outputs straight from the state register
   assign rdata_o = st_ff.rdata;
   assign ack_o = st_ff.ack;
   assign deny_o = st_ff.deny;
   assign locked_indication_o = st_ff.locked_indication;
   assign clear_done_o = st_ff.clr_done;
   assign clear_refused_o = st_ff.clr_ref;
   assign run_dir_o = st_ff.dir;
   assign nv_o = '{level: st_ff.level, password: st_ff.password,
                   locked: st_ff.locked, err: st_ff.err};

   //------------------------------------------------------------
   // Checks
   //------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_no_reverse: assert property ((st_ff.dirlim == DL_NO_REV) |=> !run_dir_o.rev)
      else $error("reverse passed while limited");
   a_no_forward: assert property ((st_ff.dirlim == DL_NO_FWD) |=> !run_dir_o.fwd)
      else $error("forward passed while limited");
   a_entry_hidden: assert property ((rd_i && addr_i == PN_ENTRY && st_ff.locked)
      |=> rdata_o <= 16'h0005)
      else $error("lock entry read exposed password");
   a_entry_nolvl: assert property ((wr_i && addr_i == PN_ENTRY && !acc_i.self_upd &&
      !rd_i && st_ff.level == V_NONE) |=> deny_o && !ack_o)
      else $error("entry write taken without lock level");
   a_lockout_keep: assert property ((wr_i && addr_i == PN_ENTRY && lockout &&
      !all_clear_i && !nv_load_i) |=> st_ff.locked && st_ff.err == ERR_LIMIT)
      else $error("lockout released by entry");
   a_clear_running: assert property ((all_clear_i && running_i)
      |=> clear_refused_o && !clear_done_o)
      else $error("full clear while running");
   a_unlock_zero: assert property ($fell(st_ff.locked) |-> st_ff.err == 3'h0)
      else $error("unlock left error count");
   a_locked_indication_deny: assert property (locked_indication_o |-> deny_o)
      else $error("locked indication without refusal");
   a_err_bound: assert property (st_ff.err <= ERR_LIMIT)
      else $error("error count above limit");
   a_read_answer: assert property (rd_i |=> (ack_o ^ deny_o))
      else $error("read not answered once");
   // Refusals and grants seen at the answer
   a_net_scope: assert property ((rd_i && acc_i.network_mode && !acc_i.simple && !acc_i.self_upd &&
      st_ff.scope == SC_SIMPLE && st_ff.lsrc == LS_NET_SCOPE) |=> deny_o)
      else $error("network read passed hidden scope");
   a_guard_list: assert property ((wr_i && !rd_i && !acc_i.self_upd &&
      st_ff.wguard == WG_NONE && addr_i == PN_DIRLIM) |=> deny_o)
      else $error("write passed guard one");
   a_guard_stop: assert property ((wr_i && !rd_i && running_i && st_ff.wguard == WG_STOP &&
      addr_i == PN_DIRLIM && !acc_i.self_upd && !acc_i.anytime) |=> deny_o)
      else $error("write passed stop guard while running");
   a_lock_rights: assert property ((rd_i && st_ff.locked && !acc_i.self_upd &&
      addr_i == PN_DIRLIM && lvl_idx(st_ff.level) == 3'h4) |=> deny_o && locked_indication_o)
      else $error("read passed lock level four");
   a_level_locked: assert property ((wr_i && !rd_i && addr_i == PN_LVL && st_ff.locked &&
      !acc_i.self_upd) |=> deny_o)
      else $error("lock level changed while locked");
   a_self_pass: assert property ((wr_i && !rd_i && acc_i.self_upd)
      |=> ack_o && !locked_indication_o)
      else $error("internal update refused");
   a_contrast_free: assert property ((rd_i && addr_i == PN_CONTRAST && pu_connected_i &&
      !acc_i.self_upd && (acc_i.simple || st_ff.scope != SC_SIMPLE)) |=> ack_o)
      else $error("contrast read refused with unit");
   a_clear_unlock: assert property ((all_clear_i && !running_i && st_ff.wguard != WG_NONE &&
      !nv_load_i) |=> clear_done_o && !st_ff.locked && st_ff.err == 3'h0)
      else $error("full clear left lock state");

   c_register: cover property (wr_i && addr_i == PN_ENTRY ##1 ack_o && st_ff.locked);
   c_unlock: cover property ($fell(st_ff.locked) && !clear_done_o);
   c_lockout: cover property (lockout);
   c_lock_deny: cover property (locked_indication_o);
   c_stop_only: cover property (wr_i && acc_i.stoponly && running_i && st_ff.wguard == WG_ANY);

endmodule

/* core/pag_pkg.sv */
// Constants and types for the setting-store access guard
//------------------------------------------------------------
//------------------------------------------------------------
package pag_pkg;

   // Setting numbers seen on the access port
   localparam logic [9:0] PN_STALL_LVL = 10'h016;
   localparam logic [9:0] PN_RESET_SEL = 10'h04b;
   localparam logic [9:0] PN_WGUARD = 10'h04d;
   localparam logic [9:0] PN_DIRLIM = 10'h04e;
   localparam logic [9:0] PN_OPMODE = 10'h04f;
   localparam logic [9:0] PN_SCOPE = 10'h0a0;
   localparam logic [9:0] PN_LVL = 10'h128;
   localparam logic [9:0] PN_ENTRY = 10'h129;
   localparam logic [9:0] PN_LSRC = 10'h227;
   localparam logic [9:0] PN_CONTRAST = 10'h3df;

   // Setting values and reset values
   localparam logic [15:0] V_NONE = 16'h270f;
   localparam logic [15:0] V_ZERO = 16'h0000;
   localparam logic [15:0] DL_BOTH = 16'h0000;
   localparam logic [15:0] DL_NO_REV = 16'h0001;
   localparam logic [15:0] DL_NO_FWD = 16'h0002;
   localparam logic [15:0] SC_ALL = 16'h0000;
   localparam logic [15:0] SC_SIMPLE = 16'h270f;
   localparam logic [15:0] WG_STOP = 16'h0000;
   localparam logic [15:0] WG_NONE = 16'h0001;
   localparam logic [15:0] WG_ANY = 16'h0002;
   localparam logic [15:0] LS_NET_SCOPE = 16'h0002;
   localparam logic [15:0] LS_RST = 16'h270f;
   localparam logic [15:0] PW_MIN = 16'h03e8;
   localparam logic [15:0] PW_MAX = 16'h270e;
   localparam logic [15:0] LV_MIN = 16'h0001;
   localparam logic [15:0] LV_MAX = 16'h0006;
   localparam logic [15:0] LV_CNT_MIN = 16'h0065;
   localparam logic [15:0] LV_CNT_MAX = 16'h006a;
   localparam logic [15:0] LV_CNT_BASE = 16'h0064;
   localparam logic [2:0] ERR_LIMIT = 3'h5;

   // Attributes of one guarded access
   typedef struct packed {
      logic network_mode;      // From network port, else local unit
      logic simple;   // Setting belongs to simple mode
      logic anytime;  // Writable during run at guard 0
      logic stoponly; // Not writable during run at guard 2
      logic self_upd; // Internal update by the device
   } pag_acc_s;

   // Direction command pair
   typedef struct packed {
      logic fwd;
      logic rev;
   } pag_dir_s;

   // Image kept in nonvolatile storage
   typedef struct packed {
      logic [15:0] level;
      logic [15:0] password;
      logic locked;
      logic [2:0] err;
   } pag_nv_s;

endpackage

/* verif/pag_host_model.sv */
// Local unit and network host that drive the guarded access port
`timescale 1ns/1ns
module pag_host_model import pag_pkg::*; (
   input wire logic clk_i,
   output logic [9:0] addr_o,
   output logic [15:0] wdata_o,
   output logic wr_o,
   output logic rd_o,
   output pag_acc_s acc_o,
   input wire logic ack_i,
   input wire logic deny_i,
   input wire logic lockd_i,
   input wire logic [15:0] rdata_i
);
   // Idle values of the released port
   initial begin
      addr_o = 10'h3ff;
      wdata_o = 16'hffff;
      wr_o = 1'b0;
      rd_o = 1'b0;
      acc_o = 5'h1f;
   end

   // One access: strobe for one cycle, answer taken in the cycle after
   task automatic xfer(input pag_acc_s acc, input logic wr, input logic [9:0] a,
         input logic [15:0] d, output logic [18:0] ans);
      @(posedge clk_i);
      addr_o <= a;
      wdata_o <= d;
      wr_o <= wr;
      rd_o <= !wr;
      acc_o <= acc;
      @(posedge clk_i);
      wr_o <= 1'b0;
      rd_o <= 1'b0;
      // Released lines show the inverse so stale values never match
      addr_o <= ~a;
      wdata_o <= ~d;
      acc_o <= ~acc;
      #1;
      ans = {ack_i, deny_i, lockd_i, rdata_i};
   endtask
endmodule

/* verif/param_access_guard_test.sv */
// Self-checking testbench of the setting-store access guard
`timescale 1ns/1ns
module param_access_guard_test;
   import pag_pkg::*;
   localparam pag_acc_s LS = 5'b01000;
   localparam pag_acc_s LX = 5'b00000;
   localparam pag_acc_s NS = 5'b11000;
   localparam pag_acc_s NX = 5'b10000;
   localparam pag_acc_s SELF = 5'b01001;
   localparam logic [15:0] PW = 16'h04d2;
   logic clk_i, rst_i, wr, rd, lockd, ack, deny, running, pu_conn, all_clear;
   logic clr_done, clr_ref, fwd_t, rev_t, nv_load;
   logic [9:0] addr;
   logic [15:0] wdata, rdata, lv;
   pag_acc_s acc_w;
   pag_dir_s panel_dir, net_dir, run_dir;
   pag_nv_s nv_in, nv_out;
   logic [3:0] rights [6] = '{4'b1010, 4'b1011, 4'b1110, 4'b0000, 4'b0011, 4'b1100};
   logic [3:0] t;
   int bad_count = 0;
   int checks_done = 0;

   pag_guard dut (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr), .wdata_i(wdata), .wr_i(wr),
      .rd_i(rd), .acc_i(acc_w), .rdata_o(rdata), .ack_o(ack), .deny_o(deny),
      .locked_indication_o(lockd), .running_i(running), .pu_connected_i(pu_conn),
      .all_clear_i(all_clear), .clear_done_o(clr_done), .clear_refused_o(clr_ref),
      .forward_start_i(fwd_t), .reverse_start_i(rev_t), .panel_dir_i(panel_dir),
      .net_dir_i(net_dir), .run_dir_o(run_dir), .nv_load_i(nv_load), .nv_i(nv_in),
      .nv_o(nv_out));
   pag_host_model host (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd),
      .acc_o(acc_w), .ack_i(ack), .deny_i(deny), .lockd_i(lockd), .rdata_i(rdata));

   //------------------------------------------------------------
   // Checking and access tasks
   //------------------------------------------------------------
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checks_done++;
      if (seen !== exp) begin
         bad_count++;
         $display("FAIL t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // Access with expected grant, lock flag and read data
   task automatic xs(input pag_acc_s a, input logic w, input logic [9:0] n,
         input logic [15:0] d, input logic ok, input logic lk, input logic [15:0] r);
      logic [18:0] ans;
      host.xfer(a, w, n, d, ans);
      check(36'(ans), 36'({ok, !ok, lk, (ok && !w) ? r : 16'h0000}));
   endtask

   // Full clear pulse and its answer
   task automatic clr(input logic done);
      @(posedge clk_i);
      all_clear <= 1'b1;
      @(posedge clk_i);
      all_clear <= 1'b0;
      #1;
      check(36'({clr_done, clr_ref}), 36'({done, !done}));
   endtask

   task automatic summarize();
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   //------------------------------------------------------------
   // Clock and watchdog
   //------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #25 clk_i = ~clk_i;
   end

   initial begin
      repeat (20000) @(posedge clk_i);
      bad_count++;
      summarize();
   end

   //------------------------------------------------------------
   // Main sequence
   //------------------------------------------------------------
   initial begin
      rst_i = 1'b1;
      running = 1'b0;
      pu_conn = 1'b1;
      all_clear = 1'b0;
      fwd_t = 1'b0;
      rev_t = 1'b0;
      panel_dir = 2'b00;
      net_dir = 2'b00;
      nv_load = 1'b0;
      nv_in = {V_NONE, V_ZERO, 1'b0, 3'h0};
      repeat (16) @(posedge clk_i);
      rst_i <= 1'b0;
      #1;
      check(36'(nv_out), 36'({V_NONE, V_ZERO, 1'b0, 3'h0}));
      xs(LS, 0, PN_LVL, 0, 1, 0, V_NONE);
      xs(LS, 0, PN_ENTRY, 0, 1, 0, V_NONE);
      xs(LS, 0, PN_DIRLIM, 0, 1, 0, DL_BOTH);
      xs(LS, 0, PN_SCOPE, 0, 1, 0, SC_ALL);
      xs(LS, 1, PN_ENTRY, PW, 0, 0, 0);
      xs(LS, 1, PN_DIRLIM, 16'h0003, 0, 0, 0);
      // Every limit value against every start source and direction
      for (int dl = 0; dl < 3; dl++) begin
         xs(LS, 1, PN_DIRLIM, 16'(dl), 1, 0, 0);
         for (int k = 0; k < 6; k++) begin
            logic [1:0] v;
            v = (k % 2 == 1) ? 2'b01 : 2'b10;
            @(posedge clk_i);
            panel_dir <= (k < 2) ? v : 2'b00;
            net_dir <= (k / 2 == 1) ? v : 2'b00;
            fwd_t <= (k == 4);
            rev_t <= (k == 5);
            repeat (6) @(posedge clk_i);
            #1;
            check(36'(run_dir), 36'({v[1] && dl != 2, v[0] && dl != 1}));
         end
      end
      @(posedge clk_i);
      rev_t <= 1'b0;
      xs(LS, 1, PN_DIRLIM, DL_BOTH, 1, 0, 0);
      // Scope changes while running, local and network reads
      @(posedge clk_i);
      running <= 1'b1;
      xs(LS, 1, PN_SCOPE, SC_SIMPLE, 1, 0, 0);
      xs(LS, 1, PN_DIRLIM, DL_BOTH, 0, 0, 0);
      xs(LX, 0, PN_DIRLIM, 0, 0, 0, 0);
      xs(NX, 0, PN_DIRLIM, 0, 1, 0, DL_BOTH);
      xs(LX, 1, PN_LVL, V_NONE, 0, 0, 0);
      xs(LS, 1, PN_SCOPE, SC_ALL, 1, 0, 0);
      xs(LX, 1, PN_LVL, V_NONE, 1, 0, 0);
      clr(0);
      @(posedge clk_i);
      running <= 1'b0;
      // Write guard 1 keeps only the short list writable
      xs(LS, 1, PN_WGUARD, WG_NONE, 1, 0, 0);
      xs(LS, 1, PN_DIRLIM, DL_BOTH, 0, 0, 0);
      xs(LS, 1, PN_SCOPE, SC_ALL, 1, 0, 0);
      xs(LS, 0, PN_DIRLIM, 0, 1, 0, DL_BOTH);
      xs(LS, 1, PN_WGUARD, WG_STOP, 1, 0, 0);
      // Per-port rights at every lock level, both error modes
      for (int i = 0; i < 12; i++) begin
         lv = (i < 6) ? 16'(i + 1) : 16'(i + 95);
         t = rights[i % 6];
         xs(LS, 1, PN_LVL, lv, 1, 0, 0);
         xs(LS, 1, PN_ENTRY, PW, 1, 0, 0);
         xs(LS, 1, PN_LVL, lv, 0, 0, 0);
         xs(LS, 0, PN_ENTRY, 0, 1, 0, 0);
         xs(LS, 0, PN_DIRLIM, 0, t[3], !t[3], DL_BOTH);
         xs(LS, 1, PN_DIRLIM, 0, t[2], !t[2], 0);
         xs(NS, 0, PN_DIRLIM, 0, t[1], !t[1], DL_BOTH);
         xs(NS, 1, PN_DIRLIM, 0, t[0], !t[0], 0);
         xs(LS, 0, PN_CONTRAST, 0, 1, 0, 0);
         @(posedge clk_i);
         pu_conn <= 1'b0;
         xs(LS, 0, PN_CONTRAST, 0, t[3], !t[3], 0);
         @(posedge clk_i);
         pu_conn <= 1'b1;
         xs(LS, 1, PN_ENTRY, 16'h04d3, 1, 0, 0);
         xs(LS, 0, PN_ENTRY, 0, 1, 0, (i < 6) ? 16'h0000 : 16'h0001);
         xs(LS, 1, PN_ENTRY, PW, 1, 0, 0);
         xs(LS, 0, PN_ENTRY, 0, 1, 0, V_NONE);
      end
      // Lockout after five errors, then full clear
      xs(LS, 1, PN_LVL, 16'h0065, 1, 0, 0);
      xs(LS, 1, PN_ENTRY, PW, 1, 0, 0);
      check(36'(nv_out), 36'({16'h0065, PW, 1'b1, 3'h0}));
      for (int e = 0; e < 5; e++) begin
         xs(NS, 1, PN_ENTRY, 16'h1f3f, 1, 0, 0);
      end
      xs(LS, 0, PN_ENTRY, 0, 1, 0, 16'h0005);
      xs(LS, 1, PN_ENTRY, PW, 1, 0, 0);
      xs(LS, 1, PN_DIRLIM, 0, 0, 1, 0);
      xs(SELF, 1, PN_DIRLIM, 0, 1, 0, 0);
      xs(LS, 1, PN_SCOPE, SC_SIMPLE, 0, 1, 0);
      xs(SELF, 1, PN_SCOPE, SC_SIMPLE, 1, 0, 0);
      xs(LX, 1, PN_ENTRY, PW, 1, 0, 0);
      xs(LX, 0, PN_DIRLIM, 0, 0, 0, 0);
      @(posedge clk_i);
      running <= 1'b1;
      clr(0);
      @(posedge clk_i);
      running <= 1'b0;
      clr(1);
      xs(LS, 0, PN_LVL, 0, 1, 0, V_NONE);
      xs(LS, 0, PN_ENTRY, 0, 1, 0, V_NONE);
      xs(LS, 0, PN_SCOPE, 0, 1, 0, SC_ALL);
      // Network reads obey scope at local source 2, guard 2 stops some writes
      xs(LS, 1, PN_SCOPE, SC_SIMPLE, 1, 0, 0);
      xs(NX, 1, PN_LSRC, LS_NET_SCOPE, 1, 0, 0);
      xs(NX, 0, PN_DIRLIM, 0, 0, 0, 0);
      xs(NS, 0, PN_LSRC, 0, 1, 0, LS_NET_SCOPE);
      xs(LS, 1, PN_SCOPE, SC_ALL, 1, 0, 0);
      xs(LS, 1, PN_WGUARD, WG_ANY, 1, 0, 0);
      @(posedge clk_i);
      running <= 1'b1;
      xs(LS, 1, PN_DIRLIM, DL_BOTH, 1, 0, 0);
      xs(5'b01010, 1, PN_DIRLIM, DL_BOTH, 0, 0, 0);
      xs(LS, 1, PN_WGUARD, WG_STOP, 1, 0, 0);
      @(posedge clk_i);
      running <= 1'b0;
      // Lock restored from the nonvolatile image
      @(posedge clk_i);
      nv_in <= {16'h0001, PW, 1'b1, 3'h0};
      nv_load <= 1'b1;
      @(posedge clk_i);
      nv_load <= 1'b0;
      xs(LS, 1, PN_DIRLIM, 0, 0, 1, 0);
      xs(LS, 0, PN_ENTRY, 0, 1, 0, 0);
      xs(LS, 1, PN_ENTRY, PW, 1, 0, 0);
      xs(LS, 1, PN_DIRLIM, 0, 1, 0, 0);
      summarize();
   end
endmodule
